// ==== inc/ipm_pkg.sv ====
package ipm_pkg;
	localparam logic [7:0] ipm_ofs_general = 8'h05;
	localparam int ipm_bit_master_en = 2;
	localparam logic [7:0] ipm_ofs_scl_high = 8'h0a;
	localparam logic [7:0] ipm_ofs_scl_low = 8'h0b;
	localparam logic [7:0] ipm_rst_scl_high = 8'h7a;
	localparam logic [7:0] ipm_rst_scl_low = 8'h7a;
	localparam int ipm_tick_extra = 4;
	localparam int ipm_unit_ns = 40;
	localparam int ipm_clk_ns = 4;
	localparam int ipm_unit_cycles = (ipm_unit_ns + ipm_clk_ns - 1) / ipm_clk_ns;
	localparam int ipm_int_osc_mhz = 25;

	typedef enum logic [3:0] {
		ipm_idle = 4'h0,
		ipm_start = 4'h1,
		ipm_bit_low = 4'h2,
		ipm_bit_high = 4'h3,
		ipm_stop_low = 4'h4,
		ipm_stop_high = 4'h5,
		ipm_lost = 4'h6,
		ipm_done = 4'h7
	} ipm_state_t;

	typedef struct packed {
		logic valid;
		logic read;
		logic [6:0] addr;
		logic [7:0] data;
	} ipm_req_t;

	typedef struct packed {
		logic done;
		logic nack;
		logic [7:0] data;
	} ipm_rsp_t;
endpackage : ipm_pkg

// ==== rtl/ipm_proxy_master.sv ====
`timescale 1ns/1ns
// One instance per receive port instances share the bus pins
// wired-and and settle contention through the bus-busy check and arbitration
module ipm_proxy_master #(
	parameter int unit_cycles = ipm_pkg::ipm_unit_cycles
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Reference timebase
	input wire logic ref_present,
	input wire logic ref_tick,
	input wire logic osc_tick,
	// Register port
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Remote request from the control channel
	input wire ipm_pkg::ipm_req_t req,
	output ipm_pkg::ipm_rsp_t rsp,
	output logic busy,
	// Local slave stretch
	input wire logic slave_wait,
	output logic slave_scl_hold,
	// I2C pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_oe,
	output logic sda_oe
);
	initial
	begin
		if (unit_cycles < 1)
			$error("unit_cycles must be at least 1");
	end

	typedef struct packed {
		ipm_pkg::ipm_state_t st;
		logic master_en;
		logic [7:0] scl_high;
		logic [7:0] scl_low;
		logic [7:0] rdata;
		logic [8:0] tcnt;
		logic [7:0] sub;
		logic [4:0] bitn;
		logic [17:0] shreg;
		logic [7:0] rx;
		logic nack;
		logic bus_busy;
		logic scl_oe;
		logic sda_oe;
		logic hold;
		logic pending;
		logic setup;
		logic rd_op;
		logic busy;
		ipm_pkg::ipm_rsp_t rsp;
		logic [1:0] scl_s1;
		logic [1:0] scl_s2;
		logic [1:0] sda_s1;
		logic [1:0] sda_s2;
		logic [1:0] ref_s;
	} ipm_regs_t;

	ipm_regs_t r;
	ipm_regs_t next_r;
	logic tick;
	logic scl_q;
	logic sda_q;
	logic sda_prev;
	logic scl_prev;

	function automatic logic [8:0] ipm_ticks(input logic [7:0] f);
		ipm_ticks = {1'b0, f} + 9'(ipm_pkg::ipm_tick_extra);
	endfunction : ipm_ticks

	assign scl_q = r.scl_s2[0];
	assign sda_q = r.sda_s2[0];
	assign scl_prev = r.scl_s2[1];
	assign sda_prev = r.sda_s2[1];
	// Internal oscillator until the external reference appears
	assign tick = r.ref_s[1] ? ref_tick : osc_tick;

	always_comb
	begin
		next_r = r;
		next_r.rsp.done = 1'b0;
		next_r.scl_s1 = {r.scl_s1[0], scl_in};
		next_r.sda_s1 = {r.sda_s1[0], sda_in};
		next_r.scl_s2 = {r.scl_s2[0], r.scl_s1[1]};
		next_r.sda_s2 = {r.sda_s2[0], r.sda_s1[1]};
		next_r.ref_s = {r.ref_s[0], ref_present};
		// Bus busy tracking from START and STOP seen on the wire
		if (scl_q && scl_prev && sda_prev && !sda_q)
			next_r.bus_busy = 1'b1;
		else if (scl_q && scl_prev && !sda_prev && sda_q)
			next_r.bus_busy = 1'b0;
		if (reg_wr)
		begin
			if (reg_addr == ipm_pkg::ipm_ofs_general)
				next_r.master_en = reg_wdata[ipm_pkg::ipm_bit_master_en];
			else if (reg_addr == ipm_pkg::ipm_ofs_scl_high)
				next_r.scl_high = reg_wdata;
			else if (reg_addr == ipm_pkg::ipm_ofs_scl_low)
				next_r.scl_low = reg_wdata;
		end
		if (reg_addr == ipm_pkg::ipm_ofs_general)
			next_r.rdata = {5'h00, r.master_en, 2'h0};
		else if (reg_addr == ipm_pkg::ipm_ofs_scl_high)
			next_r.rdata = r.scl_high;
		else if (reg_addr == ipm_pkg::ipm_ofs_scl_low)
			next_r.rdata = r.scl_low;
		else
			next_r.rdata = 8'h00;
		// Local slave: stretch while waiting, then present data for the
		// low-time setup before letting SCL go
		if (slave_wait)
		begin
			next_r.hold = 1'b1;
			next_r.pending = 1'b1;
		end
		// Time base: sub is only cleared on each tick; tcnt counts down once per tick
		if (tick)
			next_r.sub = 8'h00;
		if (r.tcnt != 9'h000 && tick)
			next_r.tcnt = r.tcnt - 9'h001;
		// A new wait restarts the setup interval from scratch
		if (slave_wait)
			next_r.setup = 1'b0;
		else if (r.pending && r.st == ipm_pkg::ipm_idle)
		begin
			if (!r.setup)
			begin
				// Data is out now; SCL stays held for the low time
				next_r.tcnt = ipm_ticks(r.scl_low);
				next_r.setup = 1'b1;
			end
			else if (r.tcnt == 9'h000)
			begin
				next_r.hold = 1'b0;
				next_r.pending = 1'b0;
				next_r.setup = 1'b0;
			end
		end
		case (r.st)
			ipm_pkg::ipm_idle:
			begin
				next_r.scl_oe = 1'b0;
				next_r.sda_oe = 1'b0;
				// Blocked while enable is clear retried when bus free
				if (req.valid && r.master_en && !r.bus_busy && !r.pending)
				begin
					next_r.busy = 1'b1;
					// Reads release SDA on the data byte so the slave drives it
					next_r.shreg = {req.addr, req.read, 1'b1,
						req.read ? 8'hff : req.data, 1'b1};
					next_r.rd_op = req.read;
					next_r.bitn = 5'd18;
					next_r.nack = 1'b0;
					next_r.sda_oe = 1'b1;
					next_r.tcnt = ipm_ticks(r.scl_high);
					next_r.st = ipm_pkg::ipm_start;
				end
			end
			ipm_pkg::ipm_start:
				if (r.tcnt == 9'h000)
				begin
					next_r.scl_oe = 1'b1;
					next_r.tcnt = ipm_ticks(r.scl_low);
					next_r.st = ipm_pkg::ipm_bit_low;
				end
			ipm_pkg::ipm_bit_low:
			begin
				next_r.sda_oe = !r.shreg[17];
				if (r.tcnt == 9'h000)
				begin
					next_r.scl_oe = 1'b0;
					next_r.tcnt = ipm_ticks(r.scl_high);
					next_r.st = ipm_pkg::ipm_bit_high;
				end
			end
			ipm_pkg::ipm_bit_high:
				// Restart the high count while another master stretches SCL
				if (!scl_q)
					next_r.tcnt = ipm_ticks(r.scl_high);
				else if (r.shreg[17] && !sda_q && r.bitn != 5'd10 &&
					r.bitn != 5'd1 && !(r.rd_op && r.bitn < 5'd10))
				begin
					// Released one but saw zero: arbitration lost
					next_r.scl_oe = 1'b0;
					next_r.sda_oe = 1'b0;
					next_r.st = ipm_pkg::ipm_lost;
				end
				else if (r.tcnt == 9'h000)
				begin
					// The closing ack of a read is the master's own release
					if (r.bitn == 5'd10 || (r.bitn == 5'd1 && !r.rd_op))
						next_r.nack = r.nack | sda_q;
					else if (r.bitn == 5'd1)
						next_r.nack = r.nack;
					else if (r.bitn < 5'd10)
						next_r.rx = {r.rx[6:0], sda_q};
					next_r.shreg = {r.shreg[16:0], 1'b1};
					next_r.bitn = r.bitn - 5'd1;
					next_r.scl_oe = 1'b1;
					next_r.tcnt = ipm_ticks(r.scl_low);
					next_r.st = (r.bitn == 5'd1) ? ipm_pkg::ipm_stop_low
						: ipm_pkg::ipm_bit_low;
				end
			ipm_pkg::ipm_stop_low:
			begin
				next_r.sda_oe = 1'b1;
				if (r.tcnt == 9'h000)
				begin
					next_r.scl_oe = 1'b0;
					next_r.tcnt = ipm_ticks(r.scl_high);
					next_r.st = ipm_pkg::ipm_stop_high;
				end
			end
			ipm_pkg::ipm_stop_high:
				if (r.tcnt == 9'h000)
				begin
					next_r.sda_oe = 1'b0;
					next_r.st = ipm_pkg::ipm_done;
				end
			ipm_pkg::ipm_lost:
				// Lines already released; go back and retry once bus frees
				next_r.st = ipm_pkg::ipm_idle;
			ipm_pkg::ipm_done:
			begin
				next_r.rsp.done = 1'b1;
				next_r.rsp.nack = r.nack;
				next_r.rsp.data = r.rx;
				next_r.busy = 1'b0;
				next_r.st = ipm_pkg::ipm_idle;
			end
			default:
				next_r.st = ipm_pkg::ipm_idle;
		endcase
		if (r.st == ipm_pkg::ipm_lost)
			next_r.busy = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			r <= '0;
			r.master_en <= 1'b0;
			r.scl_high <= ipm_pkg::ipm_rst_scl_high;
			r.scl_low <= ipm_pkg::ipm_rst_scl_low;
			r.scl_s1 <= 2'h3;
			r.scl_s2 <= 2'h3;
			r.sda_s1 <= 2'h3;
			r.sda_s2 <= 2'h3;
		end
		else
			r <= next_r;
	end

	assign reg_rdata = r.rdata;
	assign rsp = r.rsp;
	assign busy = r.busy;
	assign slave_scl_hold = r.hold;
	assign scl_oe = r.scl_oe;
	assign sda_oe = r.sda_oe;
endmodule : ipm_proxy_master

// ==== test/ipm_props.sv ====
`timescale 1ns/1ns
module ipm_props(
	// Clock, reset, timebase
	input wire logic sys_clk, reset_n, ref_present, ref_tick, osc_tick,
	// Register port
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
	// Transfer and pins
	input wire ipm_pkg::ipm_rsp_t rsp,
	input wire logic busy, slave_wait, slave_scl_hold, scl_oe, sda_oe
);
	logic en, so;
	logic [7:0] hi, lo;
	logic [9:0] tc, sc;
	wire tk = ref_present ? ref_tick : osc_tick;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// tc restarts at each SCL edge and sc while waiting or not held, so widths are read directly
	always_ff @(posedge sys_clk or negedge reset_n)
		if (!reset_n)
		begin
			en <= 1'b0;
			so <= 1'b0;
			hi <= 8'h7a;
			lo <= 8'h7a;
			tc <= '0;
			sc <= '0;
		end
		else
		begin
			so <= scl_oe;
			tc <= (!busy || scl_oe != so) ? '0 : tc + 10'(tk);
			sc <= (slave_wait || !slave_scl_hold) ? '0 : sc + 10'(tk);
			if (reg_wr && reg_addr == 8'h05)
				en <= reg_wdata[2];
			if (reg_wr && reg_addr == 8'h0a)
				hi <= reg_wdata;
			if (reg_wr && reg_addr == 8'h0b)
				lo <= reg_wdata;
		end
	en_block_a: assert property (!en |-> !scl_oe && !sda_oe)
		else $error("bus driven while disabled");
	idle_quiet_a: assert property (!busy |-> !scl_oe && !sda_oe)
		else $error("bus driven while idle");
	rd_high_a: assert property
		(!reg_wr && reg_addr == 8'h0a |=> reg_rdata == hi)
		else $error("high count readback wrong");
	done_pulse_a: assert property (rsp.done |=> !rsp.done)
		else $error("done longer than a cycle");
	hi_width_a: assert property (busy && $rose(scl_oe) |-> tc >= hi + 3)
		else $error("scl high too short");
	lo_width_a: assert property (busy && $fell(scl_oe) |-> tc >= lo + 3)
		else $error("scl low too short");
	hold_rise_a: assert property (slave_wait |=> slave_scl_hold)
		else $error("stretch not held");
	setup_min_a: assert property ($fell(slave_scl_hold) |-> sc >= lo + 3)
		else $error("setup before release too short");
	cover property ($rose(busy));
	cover property (rsp.done);
	cover property ($fell(slave_scl_hold));
endmodule : ipm_props
bind ipm_proxy_master ipm_props ipm_props_inst(.*);

// ==== test/ipm_bus_model.sv ====
`timescale 1ns/1ns
module ipm_bus_model(
	// Clock and bus lines
	input wire logic sys_clk, scl, sda,
	// Test controls
	input wire logic grab,
	input wire logic [7:0] rd_byte,
	// Drive and capture
	output logic sda_pull,
	output logic [7:0] got
);
	logic ps, pd, rd;
	logic [7:0] sh;
	int n;
	// Bit index counts SCL falls after START
	always @(posedge sys_clk)
	begin
		ps <= scl;
		pd <= sda;
		if (ps && scl && pd && !sda)
			n <= 0;
		else if (ps && !scl)
			n <= n + 1;
		if (!ps && scl && n != 9 && n < 18)
			sh <= {sh[6:0], sda};
		if (ps && !scl && n == 8)
			rd <= sh[0];
		if (ps && !scl && n == 17)
			got <= sh;
	end
	// Grab models a rival master holding SDA low
	assign sda_pull = grab || n == 9 || (n == 18 && !rd) ||
		(rd && n > 9 && n < 18 && !rd_byte[17 - n]);
endmodule : ipm_bus_model

// ==== test/test_ipm_proxy_master.sv ====
`timescale 1ns/1ns
module test_ipm_proxy_master;
	logic sys_clk = 0, reset_n = 0, ref_present = 0, ref_tick = 0;
	logic osc_tick = 0, reg_wr = 0, slave_wait = 0, grab = 0;
	logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, rd_byte = '0, got;
	logic busy, slave_scl_hold, scl_oe, sda_oe, pull;
	ipm_pkg::ipm_req_t req = '0;
	ipm_pkg::ipm_rsp_t rsp;
	logic [15:0] q[$], e;
	logic [7:0] hi_t[3] = '{8'h7a, 8'h13, 8'h06};
	logic [7:0] lo_t[3] = '{8'h7a, 8'h25, 8'h0c};
	int miscompares = 0, n_compared = 0, cyc = 0, seed = 33;
	wire scl = !scl_oe;
	wire sda = !(sda_oe || pull);
	ipm_proxy_master ipm_proxy_master_inst(.*, .scl_in(scl), .sda_in(sda));
	ipm_bus_model ipm_bus_model_inst(.*, .sda_pull(pull));
	always #2 sys_clk = !sys_clk;
	always @(negedge sys_clk)
	begin
		cyc++;
		ref_tick <= cyc % 10 == 0;
		osc_tick <= cyc % 10 == 4;
		if (cyc == 90000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end
	always @(negedge sys_clk)
		if (rsp.done === 1'b1)
		begin
			e = q.pop_front();
			chk(e[15] ? rsp.data : got, e[7:0]);
			chk({7'h0, rsp.nack}, 8'h00);
		end
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge sys_clk) reg_wr = 0;
	endtask : wr
	task rdchk(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		@(negedge sys_clk) chk(reg_rdata, exp);
	endtask : rdchk
	task xfer(input logic r, input logic [6:0] a, input logic [7:0] d);
		q.push_back({r, a, r ? rd_byte : d});
		req = '{1'b1, r, a, d};
		do @(negedge sys_clk); while (rsp.done !== 1'b1);
		req.valid = 0;
	endtask : xfer
	task tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (8) @(negedge sys_clk);
		reset_n = 1;
		rdchk(8'h0a, 8'h7a);
		rdchk(8'h0b, 8'h7a);
		rdchk(8'h33, 8'h00);
		req = '{1'b1, 1'b0, 7'h55, 8'h3c};
		repeat (300) @(negedge sys_clk);
		chk({6'h0, scl_oe, sda_oe}, 8'h00);
		$display("end regs");
		foreach (hi_t[i])
		begin
			wr(8'h0a, hi_t[i]);
			wr(8'h0b, lo_t[i]);
			rdchk(8'h0a, hi_t[i]);
			rdchk(8'h0b, lo_t[i]);
			if (i == 0)
				wr(8'h05, 8'h04);
			ref_present = i > 0;
			xfer(0, i ? 7'h40 | 7'($random(seed)) : 7'h55,
				i ? 8'($random(seed)) : 8'h3c);
			$display("end mode %0d", i);
		end
		rd_byte = 8'($random(seed));
		xfer(1, 7'h66, 8'h00);
		fork
			xfer(0, 7'h71, 8'ha5);
			begin
				wait (sda_oe);
				@(negedge sys_clk) grab = 1;
				repeat (400) @(negedge sys_clk);
				chk({6'h0, scl_oe, sda_oe}, 8'h00);
				grab = 0;
			end
		join
		$display("end arbitration");
		slave_wait = 1;
		repeat (50) @(negedge sys_clk);
		chk({7'h0, slave_scl_hold}, 8'h01);
		slave_wait = 0;
		repeat (200) @(negedge sys_clk);
		chk({7'h0, slave_scl_hold}, 8'h00);
		$display("end stretch");
		tally_and_finish();
	end
endmodule : test_ipm_proxy_master
